// ==== rtl/status_regs_params.svh ====
// constants for the status, select and command register bank
`ifndef STATUS_REGS_PARAMS_SVH
`define STATUS_REGS_PARAMS_SVH

// register byte addresses
`define ADDR_STATUS_BYTE_LOW     10'h205
`define ADDR_STATUS_BYTE_MID     10'h206
`define ADDR_STATUS_BYTE_HIGH    10'h207
`define ADDR_CHECKSUM_SEED       10'h208
`define ADDR_COMMAND_RESET_CODES 10'h300
`define ADDR_DUTY_INPUT_LOW      10'h301
`define ADDR_BRAKE_DUTY_HIGH     10'h302
`define ADDR_STATUS_SELECTOR     10'h306

// command codes
`define CMD_WATCHDOG_RESTART     8'h00
`define CMD_CHECKSUM_CLEAR       8'h55
`define CMD_LATCH_OFF_RELEASE    8'hff

// reset values
`define RST_BYTE                 8'h00
`define RST_SELECTOR             4'h0
`define RST_HOLD                 16'h0000
`define RST_FLAG                 1'h0
`define RST_DUTY_HIGH            2'h0

// field positions
`define BRAKE_BIT                7
`define DUTY_HIGH_MSB            1
`define SEL_MSB                  3

// selector codes
`define SEL_PERIOD               4'h0
`define SEL_SPEED                4'h1
`define SEL_IN_DUTY              4'h2
`define SEL_IN_PERIOD            4'h3
`define SEL_IN_HIGH              4'h4
`define SEL_TARGET               4'h5
`define SEL_PI_DUTY              4'h6
`define SEL_ENERGIZE_POS         4'h7
`define SEL_OPEN_PHASE           4'h8
`define SEL_REG_CRC              4'h9
`define SEL_OUT_DUTY_MAX         4'ha
`define SEL_LEAD_ACTUAL          4'hb
`define SEL_LEAD_TARGET          4'hc
`define SEL_STATE_FLAGS          4'hd
`define SEL_TARGET_RAW           4'he

`endif

// ==== rtl/status_regs_pkg.sv ====
// types shared by the status, select and command register bank
package status_regs_pkg;
   typedef logic [7:0]  reg_byte_t;
   typedef logic [23:0] status_word_t;
   typedef logic [3:0]  status_sel_t;
   typedef logic [9:0]  reg_addr_t;
   typedef enum { cmd_none, cmd_watchdog, cmd_checksum, cmd_latch }
      cmd_kind_t;
endpackage

// ==== rtl/status_select_and_command_regs.sv ====
// status window, selector, duty, brake and command registers
//
// What this block does
// - write 00h restarts watchdog only
// - write 55h clears checksum driver-off
// - write FFh releases protection latch-off
// - other command values do nothing
// - checksum seed reads as 8-bit value
// - bit 7 at 0302h enables brake
// - duty code from 0301h and 0302h
// - 4-bit selector at 0306h, top zero
// - status word read as three bytes
// - low byte read snapshots upper bytes
// - selector change keeps held upper bytes
// - upper bytes zero before first snapshot
// - code 0h gives rotation period
// - code 1h gives speed in rpm
// - code 2h gives measured input duty
// - codes 3h, 4h give input counts
// - code 8h gives phase connection flags
// - code 5h gives target value
// - code 7h gives energizing position
`timescale 1ns/1ps
`default_nettype none
`include "status_regs_params.svh"
module status_select_and_command_regs
#(
   parameter int PERIOD_W = 20,
   parameter int COUNT_W  = 22
)
(
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst_n,
   // register port
   input  wire status_regs_pkg::reg_addr_t     i_reg_addr,
   input  wire logic                           i_reg_wr_en,
   input  wire status_regs_pkg::reg_byte_t     i_reg_wr_data,
   input  wire logic                           i_reg_rd_en,
   output var status_regs_pkg::reg_byte_t      o_reg_rd_data,
   output logic                                o_reg_rd_valid,
   // command effects
   output logic                                o_watchdog_restart,
   output logic                                o_checksum_off_clear,
   output logic                                o_latch_off_release,
   // control outputs
   output logic                                o_short_brake_enable,
   output logic [9:0]                          o_duty_input_code,
   output var status_regs_pkg::status_sel_t    o_status_source_select,
   // checksum seed from hidden registers
   input  wire status_regs_pkg::reg_byte_t     i_checksum_seed,
   // monitor values
   input  wire logic [PERIOD_W-1:0]            i_rotation_period_count,
   input  wire logic [14:0]                    i_rotation_speed_rpm,
   input  wire logic [9:0]                     i_measured_input_duty,
   input  wire logic [COUNT_W-1:0]             i_input_period_count_latched,
   input  wire logic [COUNT_W-1:0]             i_input_high_count_latched,
   input  wire logic [14:0]                    i_target_value_control,
   input  wire logic [9:0]                     i_pi_duty_result,
   input  wire logic [7:0]                     i_energizing_position,
   input  wire logic [2:0]                     i_phase_connected,
   input  wire logic [7:0]                     i_register_crc_result,
   input  wire logic [9:0]                     i_output_duty_max,
   input  wire logic [4:0]                     i_lead_angle_actual,
   input  wire logic [4:0]                     i_lead_angle_target,
   input  wire logic [2:0]                     i_state_flags,
   input  wire logic [14:0]                    i_target_value_raw,
   input  wire logic                           i_open_loop_flag
);
   import status_regs_pkg::*;

   generate
      if (PERIOD_W < 1 || COUNT_W < 1)
      begin : g_bad
         $error("monitor widths must be positive");
      end
      if (PERIOD_W > 24 || COUNT_W > 24)
      begin : g_wide
         $error("monitor widths exceed status word");
      end
   endgenerate

   // stored registers
   reg_byte_t     duty_low_reg;
   reg_byte_t     duty_low_next;
   logic          brake_reg;
   logic          brake_next;
   logic [1:0]    duty_high_reg;
   logic [1:0]    duty_high_next;
   status_sel_t   sel_reg;
   status_sel_t   sel_next;
   logic [15:0]   hold_reg;
   logic [15:0]   hold_next;
   reg_byte_t     rd_data_reg;
   reg_byte_t     rd_data_next;
   logic          rd_valid_reg;
   logic          wd_pulse_reg;
   logic          cs_pulse_reg;
   logic          lo_pulse_reg;
   cmd_kind_t     cmd_kind;

   // address decode
   wire hit_stat_low  = (i_reg_addr == `ADDR_STATUS_BYTE_LOW);
   wire hit_stat_mid  = (i_reg_addr == `ADDR_STATUS_BYTE_MID);
   wire hit_stat_high = (i_reg_addr == `ADDR_STATUS_BYTE_HIGH);
   wire hit_seed      = (i_reg_addr == `ADDR_CHECKSUM_SEED);
   wire hit_cmd       = (i_reg_addr == `ADDR_COMMAND_RESET_CODES);
   wire hit_duty_low  = (i_reg_addr == `ADDR_DUTY_INPUT_LOW);
   wire hit_brake     = (i_reg_addr == `ADDR_BRAKE_DUTY_HIGH);
   wire hit_sel       = (i_reg_addr == `ADDR_STATUS_SELECTOR);

   wire wr_cmd        = i_reg_wr_en & hit_cmd;
   wire wr_duty_low   = i_reg_wr_en & hit_duty_low;
   wire wr_brake      = i_reg_wr_en & hit_brake;
   wire wr_sel        = i_reg_wr_en & hit_sel;
   wire rd_stat_low   = i_reg_rd_en & hit_stat_low;

   // live status word
   status_word_t status_word;

   status_word_mux
   #(
      .PERIOD_W (PERIOD_W),
      .COUNT_W  (COUNT_W)
   )
   u_mux
   (
      .i_sel                        (sel_reg),
      .i_rotation_period_count      (i_rotation_period_count),
      .i_rotation_speed_rpm         (i_rotation_speed_rpm),
      .i_measured_input_duty        (i_measured_input_duty),
      .i_input_period_count_latched (i_input_period_count_latched),
      .i_input_high_count_latched   (i_input_high_count_latched),
      .i_target_value_control       (i_target_value_control),
      .i_pi_duty_result             (i_pi_duty_result),
      .i_energizing_position        (i_energizing_position),
      .i_phase_connected            (i_phase_connected),
      .i_register_crc_result        (i_register_crc_result),
      .i_output_duty_max            (i_output_duty_max),
      .i_lead_angle_actual          (i_lead_angle_actual),
      .i_lead_angle_target          (i_lead_angle_target),
      .i_state_flags                (i_state_flags),
      .i_target_value_raw           (i_target_value_raw),
      .i_open_loop_flag             (i_open_loop_flag),
      .o_status_word                (status_word)
   );

   // command decode
   always_comb
   begin
      cmd_kind = cmd_none;
      if (wr_cmd)
      begin
         case (i_reg_wr_data)
            `CMD_WATCHDOG_RESTART:  cmd_kind = cmd_watchdog;
            `CMD_CHECKSUM_CLEAR:    cmd_kind = cmd_checksum;
            `CMD_LATCH_OFF_RELEASE: cmd_kind = cmd_latch;
            default:                cmd_kind = cmd_none;
         endcase
      end
   end

   // control register next values
   // duty low byte
   assign duty_low_next  = wr_duty_low ? i_reg_wr_data : duty_low_reg;
   assign brake_next     = wr_brake ? i_reg_wr_data[`BRAKE_BIT] : brake_reg;
   assign duty_high_next = wr_brake ? i_reg_wr_data[`DUTY_HIGH_MSB:0]
                                    : duty_high_reg;
   assign sel_next       = wr_sel ? i_reg_wr_data[`SEL_MSB:0] : sel_reg;

   assign hold_next = rd_stat_low ? status_word[23:8] : hold_reg;

   // read data selection
   always_comb
   begin
      rd_data_next = rd_data_reg;
      if (i_reg_rd_en)
      begin
         rd_data_next = `RST_BYTE;
         if (hit_stat_low)
            rd_data_next = status_word[7:0];
         if (hit_stat_mid)
            rd_data_next = hold_reg[7:0];
         if (hit_stat_high)
            rd_data_next = hold_reg[15:8];
         if (hit_seed)
            rd_data_next = i_checksum_seed;
         if (hit_duty_low)
            rd_data_next = duty_low_reg;
         if (hit_brake)
            rd_data_next = {brake_reg, 5'h00, duty_high_reg};
         if (hit_sel)
            rd_data_next = {4'h0, sel_reg};
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         duty_low_reg <= `RST_BYTE;
      end
      else
      begin
         duty_low_reg <= duty_low_next;
      end
   end

   // brake bit and duty top bits
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         brake_reg     <= `RST_FLAG;
         duty_high_reg <= `RST_DUTY_HIGH;
      end
      else
      begin
         brake_reg     <= brake_next;
         duty_high_reg <= duty_high_next;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         sel_reg <= `RST_SELECTOR;
      end
      else
      begin
         sel_reg <= sel_next;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         hold_reg <= `RST_HOLD;
      end
      else
      begin
         hold_reg <= hold_next;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         rd_data_reg  <= `RST_BYTE;
         rd_valid_reg <= `RST_FLAG;
      end
      else
      begin
         rd_data_reg  <= rd_data_next;
         rd_valid_reg <= i_reg_rd_en;
      end
   end

   // command pulses, one cycle each
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         wd_pulse_reg <= `RST_FLAG;
         cs_pulse_reg <= `RST_FLAG;
         lo_pulse_reg <= `RST_FLAG;
      end
      else
      begin
         wd_pulse_reg <= (cmd_kind == cmd_watchdog);
         cs_pulse_reg <= (cmd_kind == cmd_checksum);
         lo_pulse_reg <= (cmd_kind == cmd_latch);
      end
   end

   assign o_reg_rd_data          = rd_data_reg;
   assign o_reg_rd_valid         = rd_valid_reg;
   assign o_watchdog_restart     = wd_pulse_reg;
   assign o_checksum_off_clear   = cs_pulse_reg;
   assign o_latch_off_release    = lo_pulse_reg;
   assign o_short_brake_enable   = brake_reg;
   assign o_duty_input_code      = {duty_high_reg, duty_low_reg};
   assign o_status_source_select = sel_reg;
endmodule
`default_nettype wire

// ==== rtl/status_word_mux.sv ====
// monitor selection into the 24-bit status word
`timescale 1ns/1ps
`default_nettype none
`include "status_regs_params.svh"
module status_word_mux
#(
   parameter int PERIOD_W = 20,
   parameter int COUNT_W  = 22
)
(
   input  wire status_regs_pkg::status_sel_t  i_sel,
   input  wire logic [PERIOD_W-1:0]           i_rotation_period_count,
   input  wire logic [14:0]                   i_rotation_speed_rpm,
   input  wire logic [9:0]                    i_measured_input_duty,
   input  wire logic [COUNT_W-1:0]            i_input_period_count_latched,
   input  wire logic [COUNT_W-1:0]            i_input_high_count_latched,
   input  wire logic [14:0]                   i_target_value_control,
   input  wire logic [9:0]                    i_pi_duty_result,
   input  wire logic [7:0]                    i_energizing_position,
   input  wire logic [2:0]                    i_phase_connected,
   input  wire logic [7:0]                    i_register_crc_result,
   input  wire logic [9:0]                    i_output_duty_max,
   input  wire logic [4:0]                    i_lead_angle_actual,
   input  wire logic [4:0]                    i_lead_angle_target,
   input  wire logic [2:0]                    i_state_flags,
   input  wire logic [14:0]                   i_target_value_raw,
   input  wire logic                          i_open_loop_flag,
   output var status_regs_pkg::status_word_t   o_status_word
);
   import status_regs_pkg::*;

   generate
      if (PERIOD_W > 24 || COUNT_W > 24)
      begin : g_bad
         $error("monitor widths exceed status word");
      end
   endgenerate

   // all phases connected summary
   wire all_connected = &i_phase_connected;

   always_comb
   begin
      o_status_word = '0;
      case (i_sel)
         `SEL_PERIOD:       o_status_word = 24'(i_rotation_period_count);
         `SEL_SPEED:        o_status_word = 24'(i_rotation_speed_rpm);
         `SEL_IN_DUTY:      o_status_word = 24'(i_measured_input_duty);
         `SEL_IN_PERIOD:    o_status_word = 24'(i_input_period_count_latched);
         `SEL_IN_HIGH:      o_status_word = 24'(i_input_high_count_latched);
         `SEL_TARGET:       o_status_word = 24'(i_target_value_control);
         `SEL_PI_DUTY:      o_status_word = 24'(i_pi_duty_result);
         `SEL_ENERGIZE_POS: o_status_word = 24'(i_energizing_position);
         `SEL_OPEN_PHASE:   o_status_word = 24'({all_connected,
                                                 i_phase_connected});
         `SEL_REG_CRC:      o_status_word = 24'(i_register_crc_result);
         `SEL_OUT_DUTY_MAX: o_status_word = 24'(i_output_duty_max);
         `SEL_LEAD_ACTUAL:  o_status_word = 24'(i_lead_angle_actual);
         `SEL_LEAD_TARGET:  o_status_word = 24'(i_lead_angle_target);
         `SEL_STATE_FLAGS:  o_status_word = 24'(i_state_flags);
         `SEL_TARGET_RAW:   o_status_word = 24'({i_open_loop_flag,
                                                 i_target_value_raw});
         default:           o_status_word = '0;
      endcase
   end
endmodule
`default_nettype wire

// ==== verification/status_regs_monitor.sv ====
// assertion checker for the register port and control outputs
`timescale 1ns/1ps
`default_nettype none
`include "status_regs_params.svh"
module status_regs_monitor
(
   input wire logic                          i_core_clk,
   input wire logic                          i_rst_n,
   input wire status_regs_pkg::reg_addr_t    i_reg_addr,
   input wire logic                          i_reg_wr_en,
   input wire status_regs_pkg::reg_byte_t    i_reg_wr_data,
   input wire logic                          i_reg_rd_en,
   input wire status_regs_pkg::reg_byte_t    o_reg_rd_data,
   input wire logic                          o_reg_rd_valid,
   input wire logic                          o_watchdog_restart,
   input wire logic                          o_checksum_off_clear,
   input wire logic                          o_latch_off_release,
   input wire logic                          o_short_brake_enable,
   input wire logic [9:0]                    o_duty_input_code,
   input wire status_regs_pkg::status_sel_t  o_status_source_select
);
   import status_regs_pkg::*;
   wire cmd_wr = i_reg_wr_en && i_reg_addr == `ADDR_COMMAND_RESET_CODES;
   wire wr_301 = i_reg_wr_en && i_reg_addr == `ADDR_DUTY_INPUT_LOW;
   wire wr_302 = i_reg_wr_en && i_reg_addr == `ADDR_BRAKE_DUTY_HIGH;
   wire wr_306 = i_reg_wr_en && i_reg_addr == `ADDR_STATUS_SELECTOR;
   wire rd_306 = i_reg_rd_en && i_reg_addr == `ADDR_STATUS_SELECTOR;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_wdog;
      cmd_wr && i_reg_wr_data == 8'h00 |=> o_watchdog_restart;
   endproperty
   a_wdog: assert property (p_wdog) else $error("no watchdog pulse");
   property p_csum;
      cmd_wr && i_reg_wr_data == 8'h55 |=> o_checksum_off_clear;
   endproperty
   a_csum: assert property (p_csum) else $error("no checksum clear");
   property p_latch;
      cmd_wr && i_reg_wr_data == 8'hff |=> o_latch_off_release;
   endproperty
   a_latch: assert property (p_latch) else $error("no latch release");
   property p_no_cmd;
      o_watchdog_restart || o_checksum_off_clear || o_latch_off_release
         |-> $past(cmd_wr)
             && $past(i_reg_wr_data) inside {8'h00, 8'h55, 8'hff};
   endproperty
   a_no_cmd: assert property (p_no_cmd) else $error("stray command");
   property p_rd_valid;
      i_reg_rd_en |=> o_reg_rd_valid;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("no read valid");
   property p_brake;
      wr_302 |=> o_short_brake_enable == $past(i_reg_wr_data[7]);
   endproperty
   a_brake: assert property (p_brake) else $error("brake bit wrong");
   property p_duty;
      wr_301 |=> o_duty_input_code
         == {$past(o_duty_input_code[9:8]), $past(i_reg_wr_data)};
   endproperty
   a_duty: assert property (p_duty) else $error("duty code wrong");
   property p_sel;
      wr_306 |=> o_status_source_select == $past(i_reg_wr_data[3:0]);
   endproperty
   a_sel: assert property (p_sel) else $error("selector wrong");
   property p_rd_sel;
      rd_306 && !i_reg_wr_en
         |=> o_reg_rd_data == {4'h0, $past(o_status_source_select)};
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("selector read");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the status, select and command registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import status_regs_pkg::*;
   logic clk, rst_n, wr_en, rd_en, rd_valid, wdog, csum, latch, brake, oloop;
   reg_addr_t addr;
   reg_byte_t wr_data, rd_data, seed;
   logic [9:0] duty, in_duty, pi_duty, duty_max;
   status_sel_t sel;
   logic [19:0] period;
   logic [14:0] speed, target, raw;
   logic [21:0] per_cnt, high_cnt;
   logic [7:0] epos, crc;
   logic [2:0] phase, flags, pulses;
   logic [4:0] lead_a, lead_t;
   int bad_count, total_checks;
   status_select_and_command_regs uut (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr_en(wr_en), .i_reg_wr_data(wr_data),
      .i_reg_rd_en(rd_en), .o_reg_rd_data(rd_data), .o_reg_rd_valid(rd_valid),
      .o_watchdog_restart(wdog), .o_checksum_off_clear(csum),
      .o_latch_off_release(latch), .o_short_brake_enable(brake),
      .o_duty_input_code(duty), .o_status_source_select(sel),
      .i_checksum_seed(seed), .i_rotation_period_count(period),
      .i_rotation_speed_rpm(speed), .i_measured_input_duty(in_duty),
      .i_input_period_count_latched(per_cnt),
      .i_input_high_count_latched(high_cnt), .i_target_value_control(target),
      .i_pi_duty_result(pi_duty), .i_energizing_position(epos),
      .i_phase_connected(phase), .i_register_crc_result(crc),
      .i_output_duty_max(duty_max), .i_lead_angle_actual(lead_a),
      .i_lead_angle_target(lead_t), .i_state_flags(flags),
      .i_target_value_raw(raw), .i_open_loop_flag(oloop));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(negedge clk);
      pulses = {wdog, csum, latch};
   endtask
   task automatic rd(input reg_addr_t a, input reg_byte_t exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      check(rd_valid, 1'b1);
      check(rd_data, exp);
   endtask
   function automatic logic [23:0] mask(input logic [3:0] s);
      case (s)
         4'h0: return 24'h0fffff;
         4'h1, 4'h5: return 24'h007fff;
         4'h2, 4'h6, 4'ha: return 24'h0003ff;
         4'h3, 4'h4: return 24'h3fffff;
         4'h7, 4'h9: return 24'h0000ff;
         4'h8: return 24'h00000f;
         4'hb, 4'hc: return 24'h00001f;
         4'hd: return 24'h000007;
         4'he: return 24'h00ffff;
         default: return 24'h000000;
      endcase
   endfunction
   task automatic t_reset;
      @(negedge clk);
      check({brake, duty, sel}, 24'h0);
      rd(10'h206, 8'h00);
      rd(10'h207, 8'h00);
      rd(10'h302, 8'h00);
      rd(10'h306, 8'h00);
   endtask
   task automatic t_commands;
      reg_byte_t c [8];
      c = '{8'h00, 8'h55, 8'hff, 8'h01, 8'h54, 8'h56, 8'hfe, 8'haa};
      foreach (c[i])
      begin
         wr(10'h300, c[i]);
         check(pulses, c[i] == 8'h00 ? 3'b100 : c[i] == 8'h55 ? 3'b010 :
               c[i] == 8'hff ? 3'b001 : 3'b000);
      end
      rd(10'h300, 8'h00);
   endtask
   task automatic t_control;
      wr(10'h301, 8'ha5);
      wr(10'h302, 8'h83);
      check({brake, duty}, {1'b1, 10'h3a5});
      rd(10'h302, 8'h83);
      wr(10'h302, 8'h7e);
      check({brake, duty}, {1'b0, 10'h2a5});
      rd(10'h302, 8'h02);
      rd(10'h301, 8'ha5);
      wr(10'h306, 8'hff);
      check(sel, 4'hf);
      rd(10'h306, 8'h0f);
   endtask
   task automatic t_seed;
      rd(10'h208, 8'h3c);
      wr(10'h208, 8'h00);
      wr(10'h205, 8'hff);
      @(posedge clk) seed <= 8'hc3;
      rd(10'h208, 8'hc3);
      rd(10'h3ff, 8'h00);
   endtask
   task automatic t_snapshot;
      wr(10'h306, 8'h00);
      rd(10'h205, 8'hde);
      @(posedge clk) period <= 20'h12345;
      wr(10'h306, 8'h03);
      rd(10'h206, 8'hbc);
      rd(10'h207, 8'h0a);
      @(posedge clk) per_cnt <= 22'h3f1234;
      rd(10'h205, 8'h34);
      rd(10'h206, 8'h12);
      rd(10'h207, 8'h3f);
   endtask
   task automatic t_codes;
      logic [23:0] w;
      @(posedge clk);
      {period, speed, target, raw, oloop} <= '1;
      {in_duty, pi_duty, duty_max, per_cnt, high_cnt} <= '1;
      {epos, crc, phase, flags, lead_a, lead_t} <= '1;
      for (int s = 0; s < 16; s++)
      begin
         w = mask(s[3:0]);
         wr(10'h306, {4'h0, s[3:0]});
         rd(10'h205, w[7:0]);
         rd(10'h206, w[15:8]);
         rd(10'h207, w[23:16]);
      end
      @(posedge clk) phase <= 3'b101;
      wr(10'h306, 8'h08);
      rd(10'h205, 8'h05);
      @(posedge clk);
      {speed, in_duty, per_cnt, high_cnt} <= {15'h1, 10'h2, 22'h3, 22'h4};
      {target, pi_duty, epos, crc} <= {15'h5, 10'h6, 8'h7, 8'h9};
      {duty_max, lead_a, lead_t} <= {10'ha, 5'hb, 5'hc};
      for (int s = 1; s < 13; s++)
      begin
         if (s != 8)
         begin
            wr(10'h306, {4'h0, s[3:0]});
            rd(10'h205, {4'h0, s[3:0]});
         end
      end
   endtask
   task automatic t_rerun;
      wr(10'h306, 8'h00);
      rd(10'h205, 8'hff);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      {rst_n, wr_en, rd_en, addr, wr_data, oloop} <= '0;
      {speed, target, raw, in_duty, pi_duty, duty_max} <= '0;
      {per_cnt, high_cnt, epos, crc, phase, flags, lead_a, lead_t} <= '0;
      period <= 20'habcde;
      seed <= 8'h3c;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_commands;
      t_control;
      t_seed;
      t_snapshot;
      t_codes;
      t_rerun;
      summarize;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      summarize;
   end
endmodule
bind status_select_and_command_regs status_regs_monitor mon (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
   .i_reg_wr_en(i_reg_wr_en), .i_reg_wr_data(i_reg_wr_data),
   .i_reg_rd_en(i_reg_rd_en),
   .o_reg_rd_data(o_reg_rd_data), .o_reg_rd_valid(o_reg_rd_valid),
   .o_watchdog_restart(o_watchdog_restart),
   .o_checksum_off_clear(o_checksum_off_clear),
   .o_latch_off_release(o_latch_off_release),
   .o_short_brake_enable(o_short_brake_enable),
   .o_duty_input_code(o_duty_input_code),
   .o_status_source_select(o_status_source_select));
`default_nettype wire
